/* File: core/cotb_bank.v */
/*
 * Converter offset trim bank: APB slave, fuse-store loader, four trim
 * registers and the per-conversion trim latch for cores A and B.
 * Assumes a single 20 MHz clock, an on-chip fuse macro on the same clock
 * whose ready level may come from another domain, and a conversion strobe
 * from the datapath on this clock.
 * The bus stalls for the whole fuse load, so software never reads a trim
 * that is half way between its reset value and its factory value.
 */
`timescale 1ns/1ns
`include "cotb_regs.vh"

module cotb_bank #(
    parameter ADDR_W = 14
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [ADDR_W-1:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire pready_out,
    output wire pslverr_out,
    output wire [31:0] prdata_out,
    // Fuse store
    input wire fuse_ready_in,
    input wire fuse_valid_in,
    input wire [11:0] fuse_data_in,
    output wire fuse_rd_out,
    output wire [1:0] fuse_addr_out,
    // Operating condition
    input wire dual_mode_in,
    input wire fg_cal_en_in,
    input wire core_a_input_b_in,
    input wire core_a_phase90_in,
    input wire core_b_input_a_in,
    input wire conv_strobe_in,
    // Applied trims
    output wire [11:0] core_a_trim_out,
    output wire core_a_trim_en_out,
    output wire [11:0] core_b_trim_out,
    output wire core_b_trim_en_out,
    output wire load_done_out
);

// ST_NEXT sits between two words, so the fuse store always sees at least one
// idle cycle between read requests.
localparam ST_WAIT = 3'h0;
localparam ST_REQ = 3'h1;
localparam ST_DATA = 3'h2;
localparam ST_DONE = 3'h3;
localparam ST_NEXT = 3'h4;

localparam [1:0] LAST_IDX = 2'h3;

////////////////////////////////////////////////////////////////////////////////
// Fuse ready synchroniser.
// The fuse macro raises its ready level from its own power-up sequencer, so it is
// synchronised; its data and valid lines are on this clock and need no stages.

reg fuse_rdy_meta_r;
reg fuse_rdy_sync_r;

always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        fuse_rdy_meta_r <= 1'b0;
        fuse_rdy_sync_r <= 1'b0;
    end else begin
        fuse_rdy_meta_r <= fuse_ready_in;
        fuse_rdy_sync_r <= fuse_rdy_meta_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// APB decode.

wire [ADDR_W-3:0] word_idx;
wire setup_phase;
wire access_phase;
wire hit_ctrl;
wire hit_stat;
wire [3:0] hit_trim;
wire hit_any;
wire loading;
wire wr_done;

// Each register sits at four times its index; the two low address bits are
// ignored, so an unaligned address reaches the same word.
assign word_idx = paddr_in[ADDR_W-1:2];
assign setup_phase = psel_in && !penable_in;
assign access_phase = psel_in && penable_in;
assign hit_trim[0] = (word_idx == `COTB_IDX_A_DUAL_B);
assign hit_trim[1] = (word_idx == `COTB_IDX_A_SINGLE_A);
assign hit_trim[2] = (word_idx == `COTB_IDX_A_SINGLE_B);
assign hit_trim[3] = (word_idx == `COTB_IDX_B_INPUT_A);
assign hit_ctrl = (word_idx == `COTB_IDX_CONTROL);
assign hit_stat = (word_idx == `COTB_IDX_STATUS);
assign hit_any = (|hit_trim) || hit_ctrl || hit_stat;

// The bus waits out a fuse load so that a write can never race the loader.
assign pready_out = !loading;
assign wr_done = access_phase && pready_out && pwrite_in;
// Unmapped words and writes to the read-only status word answer with an error and change nothing.
assign pslverr_out = access_phase && pready_out && (!hit_any || (pwrite_in && hit_stat));

////////////////////////////////////////////////////////////////////////////////
// Fuse loader.

reg [2:0] state_r;
reg [2:0] state_nxt;
reg [1:0] idx_r;
reg [1:0] idx_nxt;
reg done_r;
reg done_nxt;
reg reload_pend_r;
wire reload_req;
wire [3:0] fuse_ld;

// Only the reload bit of the control word acts; the rest of the word is ignored.
assign reload_req = wr_done && hit_ctrl && pwdata_in[`COTB_CTRL_RELOAD_BIT];
assign loading = (state_r != ST_DONE);
assign fuse_rd_out = (state_r == ST_REQ);
assign fuse_addr_out = idx_r;
assign load_done_out = done_r;

always @* begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    done_nxt = done_r;
    case (state_r)
        ST_WAIT: begin
            if (fuse_rdy_sync_r) begin
                state_nxt = ST_REQ;
            end
        end
        ST_REQ: begin
            state_nxt = ST_DATA;
        end
        ST_DATA: begin
            // No time limit: a silent fuse store keeps the bus in wait states.
            if (fuse_valid_in) begin
                state_nxt = ST_NEXT;
            end
        end
        ST_NEXT: begin
            if (idx_r == LAST_IDX) begin
                // Index 0 is left ready for a later reload.
                state_nxt = ST_DONE;
                done_nxt = 1'b1;
                idx_nxt = 2'h0;
            end else begin
                state_nxt = ST_REQ;
                idx_nxt = idx_r + 2'h1;
            end
        end
        ST_DONE: begin
            if (reload_pend_r) begin
                state_nxt = ST_WAIT;
                done_nxt = 1'b0;
            end
        end
        default: begin
            state_nxt = ST_WAIT;
            idx_nxt = 2'h0;
            done_nxt = 1'b0;
        end
    endcase
end

// A reload request is held one cycle so the completing APB write ends first.
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        state_r <= ST_WAIT;
        idx_r <= 2'h0;
        done_r <= 1'b0;
        reload_pend_r <= 1'b0;
    end else begin
        state_r <= state_nxt;
        idx_r <= idx_nxt;
        done_r <= done_nxt;
        reload_pend_r <= reload_req;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Trim registers.

wire [15:0] trim_val [0:3];
wire [3:0] trim_wr;

genvar gi;
generate
    for (gi = 0; gi < `COTB_NUM_TRIMS; gi = gi + 1) begin : g_trim
        // The loader visits the indices in order, so at most one load strobe is high.
        assign fuse_ld[gi] = (state_r == ST_DATA) && fuse_valid_in && (idx_r == gi);
        assign trim_wr[gi] = wr_done && hit_trim[gi];
        cotb_trim_reg u_trim (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .wr_en_in(trim_wr[gi]),
            .wr_data_in(pwdata_in[15:0]),
            .fuse_ld_in(fuse_ld[gi]),
            .fuse_data_in(fuse_data_in),
            .value_out(trim_val[gi])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Trim selection and per-conversion latch.
// A condition that matches no trim drives the enable low, so the core runs
// untrimmed rather than with a value meant for another condition.

wire [11:0] sel_a_trim;
wire sel_a_en;
wire [1:0] sel_a_code;
wire [11:0] sel_b_trim;
wire sel_b_en;

cotb_trim_select u_select (
    .dual_mode_in(dual_mode_in),
    .fg_cal_en_in(fg_cal_en_in),
    .core_a_input_b_in(core_a_input_b_in),
    .core_a_phase90_in(core_a_phase90_in),
    .core_b_input_a_in(core_b_input_a_in),
    .trim_a_dual_b_in(trim_val[0][`COTB_TRIM_MSB:`COTB_TRIM_LSB]),
    .trim_a_single_a_in(trim_val[1][`COTB_TRIM_MSB:`COTB_TRIM_LSB]),
    .trim_a_single_b_in(trim_val[2][`COTB_TRIM_MSB:`COTB_TRIM_LSB]),
    .trim_b_input_a_in(trim_val[3][`COTB_TRIM_MSB:`COTB_TRIM_LSB]),
    .core_a_trim_out(sel_a_trim),
    .core_a_en_out(sel_a_en),
    .core_a_sel_out(sel_a_code),
    .core_b_trim_out(sel_b_trim),
    .core_b_en_out(sel_b_en)
);

reg [11:0] a_trim_r;
reg a_en_r;
reg [1:0] a_sel_r;
reg [11:0] b_trim_r;
reg b_en_r;

// Trims change only at a conversion boundary, never in mid-conversion.
// A write therefore takes effect at the next strobe under its own condition.
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        a_trim_r <= 12'h000;
        a_en_r <= 1'b0;
        a_sel_r <= 2'h0;
        b_trim_r <= 12'h000;
        b_en_r <= 1'b0;
    end else if (conv_strobe_in) begin
        a_trim_r <= sel_a_trim;
        a_en_r <= sel_a_en;
        a_sel_r <= sel_a_code;
        b_trim_r <= sel_b_trim;
        b_en_r <= sel_b_en;
    end
end

assign core_a_trim_out = a_trim_r;
assign core_a_trim_en_out = a_en_r;
assign core_b_trim_out = b_trim_r;
assign core_b_trim_en_out = b_en_r;

////////////////////////////////////////////////////////////////////////////////
// Read data.
// Reserved bits read back as written; the upper half of the word always reads zero.

reg [31:0] rd_mux;
reg [31:0] prdata_r;

always @* begin
    rd_mux = 32'h00000000;
    if (hit_trim[0]) begin
        rd_mux[15:0] = trim_val[0];
    end else if (hit_trim[1]) begin
        rd_mux[15:0] = trim_val[1];
    end else if (hit_trim[2]) begin
        rd_mux[15:0] = trim_val[2];
    end else if (hit_trim[3]) begin
        rd_mux[15:0] = trim_val[3];
    end else if (hit_stat) begin
        // Status shows the selection latched at the last conversion, not the live one.
        rd_mux[`COTB_STAT_DONE_BIT] = done_r;
        rd_mux[`COTB_STAT_ASEL_MSB:`COTB_STAT_ASEL_LSB] = a_sel_r;
        rd_mux[`COTB_STAT_AEN_BIT] = a_en_r;
        rd_mux[`COTB_STAT_BEN_BIT] = b_en_r;
    end
end

// Sampled every selected read cycle, so the word seen at the completing edge is the one sampled at the edge before it.
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        prdata_r <= 32'h00000000;
    end else if (psel_in && !pwrite_in && (setup_phase || access_phase)) begin
        prdata_r <= rd_mux;
    end
end

assign prdata_out = prdata_r;

endmodule // cotb_bank

/* File: core/cotb_regs.vh */
/*
 * Constants of the converter offset trim bank: register indices, field layout,
 * reset values and the fuse-store word count.
 * Assumes a 32-bit APB where each register takes one aligned word at four times its index.
 */
`ifndef COTB_REGS_VH
`define COTB_REGS_VH

`define COTB_IDX_A_DUAL_B 12'h346
`define COTB_IDX_A_SINGLE_A 12'h348
`define COTB_IDX_A_SINGLE_B 12'h34A
`define COTB_IDX_B_INPUT_A 12'h34C
`define COTB_IDX_CONTROL 12'h360
`define COTB_IDX_STATUS 12'h361

`define COTB_TRIM_MSB 11
`define COTB_TRIM_LSB 0
`define COTB_RSVD_MSB 15
`define COTB_RSVD_LSB 12
`define COTB_TRIM_RESET 16'h0000
`define COTB_RSVD_RESET 4'h0

`define COTB_CTRL_RELOAD_BIT 0
`define COTB_STAT_DONE_BIT 0
`define COTB_STAT_ASEL_LSB 4
`define COTB_STAT_ASEL_MSB 5
`define COTB_STAT_AEN_BIT 6
`define COTB_STAT_BEN_BIT 7

`define COTB_NUM_TRIMS 4
`define COTB_SEL_A_DUAL_B 2'h0
`define COTB_SEL_A_SINGLE_A 2'h1
`define COTB_SEL_A_SINGLE_B 2'h2

`endif

/* File: core/cotb_trim_reg.v */
/*
 * One 16-bit offset trim register: software write, fuse load and readback.
 * Assumes write and fuse load never coincide; the bus is stalled while loading.
 */
`timescale 1ns/1ns
`include "cotb_regs.vh"

module cotb_trim_reg (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Software write
    input wire wr_en_in,
    input wire [15:0] wr_data_in,
    // Fuse load
    input wire fuse_ld_in,
    input wire [11:0] fuse_data_in,
    // Contents
    output wire [15:0] value_out
);

reg [15:0] value_r;

////////////////////////////////////////////////////////////////////////////////

// Reserved bits are cleared by a fuse load since the fuse only carries the trim.
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        value_r <= `COTB_TRIM_RESET;
    end else if (fuse_ld_in) begin
        value_r <= {`COTB_RSVD_RESET, fuse_data_in};
    end else if (wr_en_in) begin
        value_r <= wr_data_in;
    end
end

assign value_out = value_r;

endmodule // cotb_trim_reg

/* File: core/cotb_trim_select.v */
/*
 * Combinational choice of the trim that each converter core uses.
 * Assumes the mode and input-select signals are stable on the core clock.
 */
`timescale 1ns/1ns
`include "cotb_regs.vh"

module cotb_trim_select (
    // Operating condition
    input wire dual_mode_in,
    input wire fg_cal_en_in,
    input wire core_a_input_b_in,
    input wire core_a_phase90_in,
    input wire core_b_input_a_in,
    // Trim values
    input wire [11:0] trim_a_dual_b_in,
    input wire [11:0] trim_a_single_a_in,
    input wire [11:0] trim_a_single_b_in,
    input wire [11:0] trim_b_input_a_in,
    // Selected trims
    output reg [11:0] core_a_trim_out,
    output reg core_a_en_out,
    output reg [1:0] core_a_sel_out,
    output reg [11:0] core_b_trim_out,
    output reg core_b_en_out
);

// Cases outside this bank (core A dual on input A, core A single on input B without phase 90, core B on input B) give no trim.
always @* begin
    core_a_trim_out = 12'h000;
    core_a_en_out = 1'b0;
    core_a_sel_out = `COTB_SEL_A_DUAL_B;
    if (fg_cal_en_in && core_a_input_b_in && core_a_phase90_in) begin
        core_a_trim_out = trim_a_single_b_in;
        core_a_en_out = 1'b1;
        core_a_sel_out = `COTB_SEL_A_SINGLE_B;
    end else if (fg_cal_en_in && dual_mode_in && core_a_input_b_in) begin
        core_a_trim_out = trim_a_dual_b_in;
        core_a_en_out = 1'b1;
        core_a_sel_out = `COTB_SEL_A_DUAL_B;
    end else if (fg_cal_en_in && !dual_mode_in && !core_a_input_b_in) begin
        core_a_trim_out = trim_a_single_a_in;
        core_a_en_out = 1'b1;
        core_a_sel_out = `COTB_SEL_A_SINGLE_A;
    end
end

always @* begin
    core_b_trim_out = 12'h000;
    core_b_en_out = 1'b0;
    if (fg_cal_en_in && core_b_input_a_in) begin
        core_b_trim_out = trim_b_input_a_in;
        core_b_en_out = 1'b1;
    end
end

endmodule // cotb_trim_select

/* File: verif/cotb_bank_assertions.sv */
/* Port-level assertions for the offset trim bank.
   Assumes it is bound to cotb_bank, one clock and an active-low reset. */
`timescale 1ns/1ns
module cotb_bank_assertions (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Bus and loader
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic pready_out,
    input wire logic [31:0] prdata_out,
    input wire logic fuse_rd_out,
    // Conditions and trims
    input wire logic dual_mode_in,
    input wire logic fg_cal_en_in,
    input wire logic core_a_input_b_in,
    input wire logic core_a_phase90_in,
    input wire logic core_b_input_a_in,
    input wire logic conv_strobe_in,
    input wire logic [11:0] core_a_trim_out,
    input wire logic core_a_trim_en_out,
    input wire logic [11:0] core_b_trim_out,
    input wire logic core_b_trim_en_out
);
default clocking cb @(posedge clk_in); endclocking
default disable iff (!rst_n_in);
////////////////////////////////////////////////////////////
sequence s_fg_strobe;
    conv_strobe_in && fg_cal_en_in;
endsequence
property p_a_dual_b;
    s_fg_strobe ##0 (dual_mode_in && core_a_input_b_in) |=> core_a_trim_en_out;
endproperty
a_a_dual_b: assert property (p_a_dual_b) else $error("core A trim off, dual B");
property p_a_single_a;
    s_fg_strobe ##0 (!dual_mode_in && !core_a_input_b_in) |=> core_a_trim_en_out;
endproperty
a_a_single_a: assert property (p_a_single_a) else $error("core A trim off, single A");
property p_a_phase90;
    s_fg_strobe ##0 (core_a_input_b_in && core_a_phase90_in) |=> core_a_trim_en_out;
endproperty
a_a_phase90: assert property (p_a_phase90) else $error("core A trim off, phase 90");
property p_b_input_a;
    s_fg_strobe ##0 core_b_input_a_in |=> core_b_trim_en_out;
endproperty
a_b_input_a: assert property (p_b_input_a) else $error("core B trim off");
property p_loading_stall;
    fuse_rd_out |-> !pready_out;
endproperty
a_loading_stall: assert property (p_loading_stall) else $error("bus answered during load");
property p_read_upper;
    psel_in && penable_in && pready_out && !pwrite_in |-> prdata_out[31:16] == 16'h0000;
endproperty
a_read_upper: assert property (p_read_upper) else $error("read data upper half set");
property p_hold_trim;
    !conv_strobe_in |=> $stable(core_a_trim_out) && $stable(core_b_trim_out);
endproperty
a_hold_trim: assert property (p_hold_trim) else $error("trim changed without strobe");
endmodule // cotb_bank_assertions

/* File: verif/test_cotb_bank.sv */
/* Self-checking bench for the offset trim bank.
   Assumes the bench plays APB master, fuse store and datapath. */
`timescale 1ns/1ns
`include "cotb_regs.vh"
module test_cotb_bank;
logic clk_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
logic fuse_ready_in = 0, fuse_valid_in = 0, conv_strobe_in = 0;
logic dual_mode_in = 0, fg_cal_en_in = 0, core_a_input_b_in = 0, core_a_phase90_in = 0, core_b_input_a_in = 0;
logic [13:0] paddr_in = 14'h0000;
logic [31:0] pwdata_in = 32'h00000000, rdat;
logic [11:0] fuse_data_in = 12'h000, fuse_mem [4];
logic [15:0] trim [4];
logic [13:0] ta [4];
logic rerr;
wire pready_out, pslverr_out, fuse_rd_out, core_a_trim_en_out, core_b_trim_en_out, load_done_out;
wire [31:0] prdata_out;
wire [1:0] fuse_addr_out;
wire [11:0] core_a_trim_out, core_b_trim_out;
integer error_cnt = 0, tests_run = 0, seed = 85, i;
cotb_bank #(.ADDR_W(14)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
    .fuse_ready_in(fuse_ready_in), .fuse_valid_in(fuse_valid_in), .fuse_data_in(fuse_data_in),
    .fuse_rd_out(fuse_rd_out), .fuse_addr_out(fuse_addr_out), .dual_mode_in(dual_mode_in),
    .fg_cal_en_in(fg_cal_en_in), .core_a_input_b_in(core_a_input_b_in),
    .core_a_phase90_in(core_a_phase90_in), .core_b_input_a_in(core_b_input_a_in),
    .conv_strobe_in(conv_strobe_in), .core_a_trim_out(core_a_trim_out),
    .core_a_trim_en_out(core_a_trim_en_out), .core_b_trim_out(core_b_trim_out),
    .core_b_trim_en_out(core_b_trim_en_out), .load_done_out(load_done_out));
initial forever #25 clk_in = ~clk_in;
////////////////////////////////////////////////////////////
// Fuse data is scrambled outside a read so a late capture shows.
always @(posedge clk_in) begin
    fuse_valid_in <= fuse_rd_out;
    fuse_data_in <= fuse_rd_out ? fuse_mem[fuse_addr_out] : ~fuse_data_in;
end
task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1; penable_in <= 0; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rdat = prdata_out;
    rerr = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
endtask
task chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
        error_cnt++;
        $display("CHECK FAILED time=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
function automatic logic [25:0] exp_trims(input logic [4:0] c);
    logic [12:0] a, b;
    a = 13'h0000;
    b = 13'h0000;
    if (c[0] && c[2] && c[3]) a = {1'b1, trim[2][11:0]};
    else if (c[0] && c[1] && c[2]) a = {1'b1, trim[0][11:0]};
    else if (c[0] && !c[1] && !c[2]) a = {1'b1, trim[1][11:0]};
    if (c[0] && c[4]) b = {1'b1, trim[3][11:0]};
    return {a, b};
endfunction
task print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask
////////////////////////////////////////////////////////////
initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    print_verdict;
end
initial begin
    ta = '{14'(`COTB_IDX_A_DUAL_B * 4), 14'(`COTB_IDX_A_SINGLE_A * 4),
        14'(`COTB_IDX_A_SINGLE_B * 4), 14'(`COTB_IDX_B_INPUT_A * 4)};
    for (i = 0; i < 4; i++) fuse_mem[i] = 12'($random(seed));
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1;
    fuse_ready_in <= 1;
    for (i = 0; i < 4; i++) begin
        apb(0, ta[i], 32'h00000000);
        chk(rdat, {20'h00000, fuse_mem[i]});
    end
    chk(load_done_out, 1'h1);
    for (i = 0; i < 4; i++) begin
        trim[i] = (i == 0) ? 16'hF000 : 16'($random(seed));
        apb(1, ta[i], {16'hA5A5, trim[i]});
        apb(0, ta[i], 32'h00000000);
        chk(rdat, {16'h0000, trim[i]});
    end
    apb(0, 14'h0000, 32'h00000000);
    chk({rerr, rdat}, 33'h100000000);
    for (i = 0; i < 32; i++) begin
        @(posedge clk_in);
        {core_b_input_a_in, core_a_phase90_in, core_a_input_b_in, dual_mode_in, fg_cal_en_in} <= i[4:0];
        conv_strobe_in <= 1;
        @(posedge clk_in);
        conv_strobe_in <= 0;
        @(negedge clk_in);
        chk({6'h00, core_a_trim_en_out, core_a_trim_out, core_b_trim_en_out, core_b_trim_out},
            {6'h00, exp_trims(i[4:0])});
    end
    apb(0, 14'(`COTB_IDX_STATUS * 4), 32'h00000000);
    chk(rdat, (64'h1 << `COTB_STAT_DONE_BIT) | (64'(`COTB_SEL_A_SINGLE_B) << `COTB_STAT_ASEL_LSB) |
        (64'h1 << `COTB_STAT_AEN_BIT) | (64'h1 << `COTB_STAT_BEN_BIT));
    apb(1, 14'(`COTB_IDX_STATUS * 4), 32'hFFFFFFFF);
    chk(rerr, 1'h1);
    apb(0, 14'(`COTB_IDX_CONTROL * 4), 32'h00000000);
    chk({rerr, rdat}, 33'h000000000);
    apb(1, 14'(`COTB_IDX_CONTROL * 4), 32'h00000001);
    for (i = 0; i < 4; i++) begin
        apb(0, ta[i], 32'h00000000);
        chk(rdat, {20'h00000, fuse_mem[i]});
    end
    chk(load_done_out, 1'h1);
    print_verdict;
end
endmodule // test_cotb_bank
bind cotb_bank cotb_bank_assertions chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .pready_out(pready_out), .prdata_out(prdata_out),
    .fuse_rd_out(fuse_rd_out), .dual_mode_in(dual_mode_in), .fg_cal_en_in(fg_cal_en_in),
    .core_a_input_b_in(core_a_input_b_in), .core_a_phase90_in(core_a_phase90_in),
    .core_b_input_a_in(core_b_input_a_in), .conv_strobe_in(conv_strobe_in),
    .core_a_trim_out(core_a_trim_out), .core_a_trim_en_out(core_a_trim_en_out),
    .core_b_trim_out(core_b_trim_out), .core_b_trim_en_out(core_b_trim_en_out));
